/* dma_step_pkg.sv */
package dma_step_pkg;

    // ------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL   = 6'h00;
    localparam logic [5:0] IDX_COUNT  = 6'h02;
    localparam logic [5:0] IDX_SRC    = 6'h04;
    localparam logic [5:0] IDX_DST    = 6'h08;
    localparam logic [5:0] IDX_NEXT   = 6'h0c;
    localparam logic [5:0] IDX_CMD    = 6'h10;
    localparam logic [5:0] IDX_STATUS = 6'h11;
    localparam logic [5:0] IDX_REMAIN = 6'h12;
    localparam logic [5:0] IDX_CURSRC = 6'h13;
    localparam logic [5:0] IDX_CURDST = 6'h14;

    // ------------------------------------------------------------
    // Control word field positions
    // ------------------------------------------------------------
    localparam int POS_VALID     = 0;
    localparam int POS_EVOUT_LO  = 1;
    localparam int POS_BLKACT_LO = 3;
    localparam int POS_BEAT_LO   = 8;
    localparam int POS_SOURCE_INCREMENT_ENABLE    = 10;
    localparam int POS_DESTINATION_INCREMENT_ENABLE    = 11;
    localparam int POS_STEP_SIDE_SELECTOR   = 12;
    localparam int POS_STEP_LO   = 13;

    // Command and status bits
    localparam int POS_CMD_START  = 0;
    localparam int POS_CMD_ABORT  = 1;
    localparam int POS_ST_BUSY    = 0;
    localparam int POS_ST_DONE    = 1;
    localparam int POS_ST_NOTRDY  = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CTRL  = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [31:0] RST_ADDR  = 32'h0000_0000;

    typedef struct packed {
        logic [2:0] step_power_field;
        logic       step_side_selector;
        logic       destination_increment_enable;
        logic       source_increment_enable;
        logic [1:0] beat_width_code;
        logic [2:0] rsvd_hi;
        logic [1:0] block_end_action;
        logic [1:0] event_output_select;
        logic       valid;
    } ctrl_t;

    typedef struct packed {
        ctrl_t       block_transfer_control_word;
        logic [15:0] block_beat_count;
        logic [31:0] source_end_address;
        logic [31:0] destination_end_address;
        logic [31:0] next_descriptor_pointer;
    } descriptor_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
    } beat_t;

endpackage

/* addr_step_calc.sv */
module addr_step_calc
    import dma_step_pkg::*;
(
    input  wire ctrl_t       ctrl,
    input  wire logic [15:0] beat_count,
    input  wire logic        side_is_src,
    output logic      [31:0] step_bytes,
    output logic      [31:0] span_bytes
);

    logic        inc_en;
    logic        use_step;
    logic [9:0]  step_raw;
    logic [25:0] span_raw;

    assign inc_en   = side_is_src ? ctrl.source_increment_enable
                                  : ctrl.destination_increment_enable;
    assign use_step = side_is_src ? ctrl.step_side_selector
                                  : ~ctrl.step_side_selector;
    assign step_raw = use_step ? (10'({1'b0, ctrl.beat_width_code} + 3'h1) << ctrl.step_power_field)
                               : 10'({1'b0, ctrl.beat_width_code} + 3'h1);
    assign span_raw = 26'(beat_count * step_raw);

    assign step_bytes = inc_en ? {22'h000000, step_raw} : 32'h0000_0000;
    assign span_bytes = inc_en ? {6'h00, span_raw} : 32'h0000_0000;

endmodule

/* dma_step_top.sv */
// Summary of operation
// - Step selector 0: source advances exactly one beat per transfer, step field ignored.
// - Source end address equals start plus count times beat bytes, scaled when selected.
// - Destination advances only with its increment enable set; otherwise stays fixed.
// - Step selector 1: destination advances one beat; 0: programmed step applies.
// - Destination end address equals start plus count times beat bytes, scaled if stepped.
// - Beat count in the arithmetic is the initial count written before starting.
// - Beat width code plus one is the byte multiplier per beat.
// - Three-bit step field gives beats per increment as a power of two.
// - Descriptor is sixteen bytes: control, count, source, destination, next pointer.
//
// Our own choice: the Avalon-MM interface to the registers.
module dma_step_top
    import dma_step_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output beat_t            beat,
    input  wire logic        beat_ready,
    output logic             channel_busy,
    output logic             block_done
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    descriptor_t desc_ff;
    logic        ack_ff;
    logic [31:0] readdata_ff;
    logic        busy_ff;
    logic        done_ff;
    logic        notrdy_ff;
    logic [15:0] remain_ff;
    logic [31:0] cur_src_ff;
    logic [31:0] cur_dst_ff;
    logic [31:0] src_step_ff;
    logic [31:0] dst_step_ff;

    logic [31:0] src_step;
    logic [31:0] src_span;
    logic [31:0] dst_step;
    logic [31:0] dst_span;
    logic [5:0]  idx;
    logic        wr_take;
    logic        start_req;
    logic        abort_req;
    logic        start_ok;
    logic        beat_take;
    logic        last_beat;
    logic        done_clr;
    logic        notrdy_clr;
    logic [31:0] be_mask;

    // ------------------------------------------------------------
    // Avalon slave handshake: one wait cycle on every access
    // ------------------------------------------------------------
    assign idx             = avs_address[7:2];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wr_take         = avs_write & ack_ff;
    assign be_mask         = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign avs_readdata    = readdata_ff;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata_ff <= 32'h0000_0000;
        end else if (avs_read & ~ack_ff) begin
            case (idx)
                IDX_CTRL:   readdata_ff <= {16'h0000, desc_ff.block_transfer_control_word};
                IDX_COUNT:  readdata_ff <= {16'h0000, desc_ff.block_beat_count};
                IDX_SRC:    readdata_ff <= desc_ff.source_end_address;
                IDX_DST:    readdata_ff <= desc_ff.destination_end_address;
                IDX_NEXT:   readdata_ff <= desc_ff.next_descriptor_pointer;
                IDX_STATUS: readdata_ff <= {29'h0000_0000, notrdy_ff, done_ff, busy_ff};
                IDX_REMAIN: readdata_ff <= {16'h0000, remain_ff};
                IDX_CURSRC: readdata_ff <= cur_src_ff;
                IDX_CURDST: readdata_ff <= cur_dst_ff;
                default:    readdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Descriptor registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            desc_ff.block_transfer_control_word <= RST_CTRL;
            desc_ff.block_beat_count            <= RST_COUNT;
            desc_ff.source_end_address          <= RST_ADDR;
            desc_ff.destination_end_address     <= RST_ADDR;
            desc_ff.next_descriptor_pointer     <= RST_ADDR;
        end else if (wr_take) begin
            case (idx)
                IDX_CTRL: begin
                    desc_ff.block_transfer_control_word <= ctrl_t'(16'(merge(
                        {16'h0000, desc_ff.block_transfer_control_word}, avs_writedata, be_mask)));
                end
                IDX_COUNT: begin
                    desc_ff.block_beat_count <= 16'(merge({16'h0000, desc_ff.block_beat_count},
                                                          avs_writedata, be_mask));
                end
                IDX_SRC: begin
                    desc_ff.source_end_address <= merge(desc_ff.source_end_address,
                                                        avs_writedata, be_mask);
                end
                IDX_DST: begin
                    desc_ff.destination_end_address <= merge(desc_ff.destination_end_address,
                                                             avs_writedata, be_mask);
                end
                IDX_NEXT: begin
                    desc_ff.next_descriptor_pointer <= merge(desc_ff.next_descriptor_pointer,
                                                             avs_writedata, be_mask);
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address step computation for each side
    // ------------------------------------------------------------
    addr_step_calc u_src_calc (
        .ctrl        (desc_ff.block_transfer_control_word),
        .beat_count  (desc_ff.block_beat_count),
        .side_is_src (1'b1),
        .step_bytes  (src_step),
        .span_bytes  (src_span)
    );

    addr_step_calc u_dst_calc (
        .ctrl        (desc_ff.block_transfer_control_word),
        .beat_count  (desc_ff.block_beat_count),
        .side_is_src (1'b0),
        .step_bytes  (dst_step),
        .span_bytes  (dst_span)
    );

    // ------------------------------------------------------------
    // Channel control
    // ------------------------------------------------------------
    assign start_req  = wr_take & (idx == IDX_CMD) & avs_byteenable[0] & avs_writedata[POS_CMD_START];
    assign abort_req  = wr_take & (idx == IDX_CMD) & avs_byteenable[0] & avs_writedata[POS_CMD_ABORT];
    assign start_ok   = start_req & ~busy_ff & desc_ff.block_transfer_control_word.valid;
    assign beat_take  = busy_ff & beat_ready;
    assign last_beat  = beat_take & (remain_ff == 16'h0001);
    assign done_clr   = wr_take & (idx == IDX_STATUS) & avs_byteenable[0] & avs_writedata[POS_ST_DONE];
    assign notrdy_clr = wr_take & (idx == IDX_STATUS) & avs_byteenable[0] & avs_writedata[POS_ST_NOTRDY];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_ff <= 1'b0;
        end else if (abort_req | last_beat) begin
            busy_ff <= 1'b0;
        end else if (start_ok & (desc_ff.block_beat_count != 16'h0000)) begin
            busy_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_ff <= 1'b0;
        end else if (last_beat | (start_ok & (desc_ff.block_beat_count == 16'h0000))) begin
            done_ff <= 1'b1;
        end else if (done_clr) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            notrdy_ff <= 1'b0;
        end else if (start_req & ~busy_ff & ~desc_ff.block_transfer_control_word.valid) begin
            notrdy_ff <= 1'b1;
        end else if (notrdy_clr) begin
            notrdy_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_step_ff <= RST_ADDR;
            dst_step_ff <= RST_ADDR;
        end else if (start_ok) begin
            src_step_ff <= src_step;
            dst_step_ff <= dst_step;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            remain_ff <= RST_COUNT;
        end else if (start_ok) begin
            remain_ff <= desc_ff.block_beat_count;
        end else if (beat_take) begin
            remain_ff <= remain_ff - 16'h0001;
        end
    end

    // Descriptor holds end addresses; the first beat starts one span below
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_src_ff <= RST_ADDR;
            cur_dst_ff <= RST_ADDR;
        end else if (start_ok) begin
            cur_src_ff <= desc_ff.source_end_address - src_span;
            cur_dst_ff <= desc_ff.destination_end_address - dst_span;
        end else if (beat_take) begin
            cur_src_ff <= cur_src_ff + src_step_ff;
            cur_dst_ff <= cur_dst_ff + dst_step_ff;
        end
    end

    // ------------------------------------------------------------
    // Beat request outputs
    // ------------------------------------------------------------
    assign beat.valid    = busy_ff;
    assign beat.src_addr = cur_src_ff;
    assign beat.dst_addr = cur_dst_ff;
    assign channel_busy  = busy_ff;
    assign block_done    = done_ff;

endmodule

/* beat_sink.sv */
module beat_sink
    import dma_step_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_b,
    input  wire beat_t beat,
    input  wire logic  stall_mode,
    output logic       beat_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_ff <= 2'h0;
        end else begin
            ph_ff <= ph_ff + 2'h1;
        end
    end
    // Stalling accepts one cycle in four
    assign beat_ready = !stall_mode || (ph_ff == 2'h3);
endmodule

/* dma_step_sva.sv */
module dma_step_sva
    import dma_step_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire beat_t       beat,
    input wire logic        beat_ready,
    input wire logic        channel_busy,
    input wire logic        block_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] ctrl_ff;
    logic [15:0] cnt_ff;
    logic [15:0] left_ff;
    logic [31:0] src_ff;
    logic [31:0] dst_ff;
    logic [31:0] s_st;
    logic [31:0] d_st;
    logic        wr_ok;
    logic        go;
    logic        acc;
    assign wr_ok = avs_write && !avs_waitrequest;
    assign go    = wr_ok && avs_address[7:2] == IDX_CMD && avs_writedata[POS_CMD_START];
    assign acc   = beat.valid && beat_ready;
    assign s_st  = ctrl_ff[POS_SOURCE_INCREMENT_ENABLE] ?
                   ({30'h0, ctrl_ff[9:8]} + 32'h1) << (ctrl_ff[POS_STEP_SIDE_SELECTOR] ? ctrl_ff[15:13] : 3'h0) : 32'h0;
    assign d_st  = ctrl_ff[POS_DESTINATION_INCREMENT_ENABLE] ?
                   ({30'h0, ctrl_ff[9:8]} + 32'h1) << (ctrl_ff[POS_STEP_SIDE_SELECTOR] ? 3'h0 : ctrl_ff[15:13]) : 32'h0;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= 16'h0;
            cnt_ff  <= 16'h0;
            src_ff  <= 32'h0;
            dst_ff  <= 32'h0;
        end else if (wr_ok) begin
            if (avs_address[7:2] == IDX_CTRL) ctrl_ff <= avs_writedata[15:0];
            if (avs_address[7:2] == IDX_COUNT) cnt_ff <= avs_writedata[15:0];
            if (avs_address[7:2] == IDX_SRC) src_ff <= avs_writedata;
            if (avs_address[7:2] == IDX_DST) dst_ff <= avs_writedata;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) left_ff <= 16'h0;
        else if (go && !channel_busy) left_ff <= cnt_ff;
        else if (acc) left_ff <= left_ff - 16'h1;
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_accept_next;
        acc ##1 beat.valid;
    endsequence
    sequence s_start;
        go && !channel_busy && ctrl_ff[POS_VALID] && cnt_ff != 16'h0;
    endsequence
    AST_WAIT_ONE: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Bus answer not after exactly one wait cycle");
    AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address[7:2] > IDX_CURDST |-> avs_readdata == 32'h0)
        else $error("Unmapped read not zero");
    AST_START_SRC: assert property (s_start |=> channel_busy && beat.src_addr == src_ff - {16'h0, cnt_ff} * s_st)
        else $error("First source address wrong");
    AST_START_DST: assert property (s_start |=> beat.dst_addr == dst_ff - {16'h0, cnt_ff} * d_st)
        else $error("First destination address wrong");
    AST_SRC_STEP: assert property (s_accept_next |-> beat.src_addr == $past(beat.src_addr) + s_st)
        else $error("Source step wrong");
    AST_DST_STEP: assert property (s_accept_next |-> beat.dst_addr == $past(beat.dst_addr) + d_st)
        else $error("Destination step wrong");
    AST_STALL_HOLD: assert property (beat.valid && !beat_ready |=> $stable(beat.src_addr) && $stable(beat.dst_addr))
        else $error("Beat changed while stalled");
    AST_LAST_DONE: assert property (acc && left_ff == 16'h1 |=> !channel_busy && block_done)
        else $error("Block not ended after last beat");
    AST_NOT_READY: assert property (go && !channel_busy && !ctrl_ff[POS_VALID] |=> !channel_busy ##1 !channel_busy)
        else $error("Invalid descriptor started");
endmodule
bind dma_step_top dma_step_sva i_sva (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .beat(beat), .beat_ready(beat_ready), .channel_busy(channel_busy), .block_done(block_done)
);

/* dma_step_top_tb.sv */
module dma_step_top_tb
    import dma_step_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk            = 1'b0;
    logic        rst_b          = 1'b0;
    logic [7:0]  avs_address    = 8'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    beat_t       beat;
    logic        beat_ready;
    logic        channel_busy;
    logic        block_done;
    logic        stall_mode     = 1'b0;
    logic [31:0] exp_src, exp_dst, s_st, d_st, seen;
    int          bad_count      = 0;
    int          check_count    = 0;
    int          cyc            = 0;
    dma_step_top i_dut (
        .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .beat(beat), .beat_ready(beat_ready),
        .channel_busy(channel_busy), .block_done(block_done)
    );
    beat_sink i_sink (
        .clk(clk), .rst_b(rst_b), .beat(beat), .stall_mode(stall_mode), .beat_ready(beat_ready)
    );
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (beat.valid === 1'b1 && beat_ready === 1'b1) begin
            chk("beat source", exp_src, beat.src_addr);
            chk("beat destination", exp_dst, beat.dst_addr);
            exp_src = exp_src + s_st;
            exp_dst = exp_dst + d_st;
            seen    = seen + 32'h1;
        end
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic run_block(input logic [15:0] c, input logic [15:0] n, input logic [31:0] se,
                             input logic [31:0] de, input logic sm);
        logic [31:0] rd;
        s_st    = c[POS_SOURCE_INCREMENT_ENABLE] ? ({30'h0, c[9:8]} + 32'h1) << (c[POS_STEP_SIDE_SELECTOR] ? c[15:13] : 3'h0) : 32'h0;
        d_st    = c[POS_DESTINATION_INCREMENT_ENABLE] ? ({30'h0, c[9:8]} + 32'h1) << (c[POS_STEP_SIDE_SELECTOR] ? 3'h0 : c[15:13]) : 32'h0;
        exp_src = se - {16'h0, n} * s_st;
        exp_dst = de - {16'h0, n} * d_st;
        seen    = 32'h0;
        stall_mode <= sm;
        bus_write({IDX_CTRL, 2'h0}, {16'h0, c});
        bus_write({IDX_COUNT, 2'h0}, {16'h0, n});
        bus_write({IDX_SRC, 2'h0}, se);
        bus_write({IDX_DST, 2'h0}, de);
        bus_read({IDX_CTRL, 2'h0}, rd);
        chk("control word", {16'h0, c}, rd);
        bus_write({IDX_CMD, 2'h0}, 32'h1);
        for (int i = 0; i < 400 && block_done !== 1'b1; i++) @(posedge clk);
        chk("beat count", {16'h0, n}, seen);
        bus_read({IDX_STATUS, 2'h0}, rd);
        chk("status", 32'h2, rd);
        bus_read({IDX_CURSRC, 2'h0}, rd);
        chk("final source", se, rd);
        bus_read({IDX_CURDST, 2'h0}, rd);
        chk("final destination", de, rd);
        bus_read({IDX_REMAIN, 2'h0}, rd);
        chk("remaining beats", 32'h0, rd);
        bus_write({IDX_STATUS, 2'h0}, 32'h2);
    endtask
    initial begin
        logic [31:0] rd;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        bus_read({IDX_COUNT, 2'h0}, rd);
        chk("count reset", {16'h0, RST_COUNT}, rd);
        bus_write(8'hfc, 32'hffff_ffff);
        bus_read(8'hfc, rd);
        chk("unmapped", 32'h0, rd);
        bus_write({IDX_NEXT, 2'h0}, 32'h0000_2230);
        bus_read({IDX_NEXT, 2'h0}, rd);
        chk("next pointer", 32'h0000_2230, rd);
        avs_byteenable <= 4'h3;
        bus_write({IDX_NEXT, 2'h0}, 32'hffff_ffff);
        avs_byteenable <= 4'hf;
        bus_read({IDX_NEXT, 2'h0}, rd);
        chk("next pointer low half", 32'h0000_ffff, rd);
        run_block(16'h4d01, 16'h0003, 32'h0000_1000, 32'h2000_0100, 1'b0);
        run_block(16'h3701, 16'h0004, 32'h0000_0100, 32'h4000_0000, 1'b1);
        run_block(16'hf801, 16'h0005, 32'h3000_0040, 32'h0000_0010, 1'b1);
        bus_write({IDX_CTRL, 2'h0}, 32'h0000_4d00);
        bus_write({IDX_CMD, 2'h0}, 32'h1);
        bus_read({IDX_STATUS, 2'h0}, rd);
        chk("not ready status", 32'h4, rd);
        // Abort a fixed-address block after a few cycles
        s_st    = 32'h0;
        d_st    = 32'h0;
        exp_src = 32'h3000_0040;
        exp_dst = 32'h0000_0010;
        bus_write({IDX_CTRL, 2'h0}, 32'h0000_0001);
        bus_write({IDX_COUNT, 2'h0}, 32'h0000_0040);
        bus_write({IDX_CMD, 2'h0}, 32'h1);
        bus_write({IDX_CMD, 2'h0}, 32'h2);
        bus_read({IDX_STATUS, 2'h0}, rd);
        chk("abort status", 32'h4, rd);
        // Empty block ends at once
        bus_write({IDX_COUNT, 2'h0}, 32'h0);
        bus_write({IDX_CMD, 2'h0}, 32'h1);
        bus_read({IDX_STATUS, 2'h0}, rd);
        chk("empty block status", 32'h6, rd);
        end_sim();
    end
endmodule
